// *** hdl/oag_operand_addr_gen.sv ***
`timescale 1ns/1ps
// Function
// - seven modes, each instruction allows subset
// - register mode yields register or pair contents
// - pointer selects 8-byte working slice
// - pointer register holds register or memory address
// - pointer mode never reaches C0h to FFh
// - base offset mode never reaches C0h-FFh
// - register base from instruction plus working offset
// - memory base pair plus instruction offset
// - short offset sign-extended, memory only
// - base offset register form only plain load
// - absolute jump and call load target
// - memory loads may take absolute address
// - vector read from lowest 256 bytes
// - vector mode only for call
// - pc offset added to next address
// - pc offset only for listed branches
// - literal is one byte or word
// - top bit picks pointer, concatenate fields
// - 1100b upper nibble means working register
module oag_operand_addr_gen
   import oag_pkg::*;
(
   input  wire logic           core_clk,
   input  wire logic           rst_b,
   input  wire logic           req_valid,
   output logic                req_ready,
   input  wire oag_mode_type   req_mode,
   input  wire oag_instr_type  req_instr,
   input  wire oag_target_type req_target,
   input  wire logic [7:0]     req_reg,
   input  wire logic           req_short_reg,
   input  wire logic           req_wide,
   input  wire logic           req_short_offset,
   input  wire logic [15:0]    req_imm,
   input  wire logic [15:0]    req_pc,
   input  wire logic [7:0]     rp0,
   input  wire logic [7:0]     rp1,
   output logic                rf_rd_en,
   output logic [7:0]          rf_rd_addr,
   input  wire logic [7:0]     rf_rd_data,
   output logic                pm_rd_en,
   output logic [15:0]         pm_rd_addr,
   input  wire logic [7:0]     pm_rd_data,
   output logic                out_valid,
   output logic                out_illegal,
   output oag_kind_type        out_kind,
   output logic [15:0]         out_value
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ_FIRST,
      ST_READ_SECOND,
      ST_CALC
   } oag_state_type;

   oag_state_type  state_r;
   oag_state_type  state_nxt;
   oag_mode_type   mode_r;
   oag_instr_type  instr_r;
   oag_target_type target_r;
   logic [7:0]     reg_r;
   logic           short_reg_r;
   logic           wide_r;
   logic           short_off_r;
   logic [15:0]    imm_r;
   logic [15:0]    pc_r;
   logic [7:0]     byte_hi_r;
   logic           out_valid_r;
   logic           out_illegal_r;
   oag_kind_type   out_kind_r;
   logic [15:0]    out_value_r;

   logic           mode_legal;
   logic [1:0]     n_reads;
   logic           use_pm;
   logic [15:0]    addr_first;
   logic [15:0]    addr_second;
   logic [15:0]    rd_addr;
   logic           rd_issue;
   logic [7:0]     rd_data;
   logic [15:0]    pair_word;
   logic [7:0]     sum_rf;
   logic [15:0]    mem_offset;
   logic [15:0]    rel_disp;
   logic           out_of_range;
   oag_kind_type   kind_nxt;
   logic [15:0]    value_nxt;
   logic           illegal_nxt;

   oag_wreg_if wr ();

   assign wr.reg_field  = reg_r;
   assign wr.short_form = short_reg_r;
   assign wr.rp0        = rp0;
   assign wr.rp1        = rp1;

   oag_wreg_resolve u_wreg (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .wr       (wr)
   );

   // which instruction may use which mode
   always_comb begin
      mode_legal = 1'b0;
      unique case (mode_r)
         MODE_REGISTER,
         MODE_LITERAL_OPERAND: begin
            mode_legal = 1'b1;
         end
         MODE_POINTER_REGISTER: begin
            mode_legal = 1'b1;
         end
         MODE_BASE_OFFSET: begin
            unique case (target_r)
               TGT_REGISTER_FILE:  mode_legal = (instr_r == INS_LOAD_REGISTER);
               TGT_PROGRAM_MEMORY: mode_legal = (instr_r == INS_LOAD_PROGRAM_MEMORY);
               TGT_EXTERNAL_DATA:  mode_legal = (instr_r == INS_LOAD_EXTERNAL_DATA);
               TGT_PROGRAM_COUNTER: mode_legal = 1'b0;
            endcase
         end
         MODE_ABSOLUTE_ADDRESS: begin
            unique case (target_r)
               TGT_PROGRAM_COUNTER: begin
                  mode_legal = (instr_r == INS_JUMP_ABSOLUTE) || (instr_r == INS_CALL);
               end
               TGT_PROGRAM_MEMORY: mode_legal = (instr_r == INS_LOAD_PROGRAM_MEMORY);
               TGT_EXTERNAL_DATA:  mode_legal = (instr_r == INS_LOAD_EXTERNAL_DATA);
               TGT_REGISTER_FILE:  mode_legal = 1'b0;
            endcase
         end
         MODE_VECTOR_TABLE_CALL: begin
            mode_legal = (instr_r == INS_CALL);
         end
         MODE_PC_OFFSET: begin
            unique case (instr_r)
               INS_JUMP_RELATIVE,
               INS_DECREMENT_BRANCH_NONZERO,
               INS_BIT_TEST_BRANCH_FALSE,
               INS_BIT_TEST_BRANCH_TRUE,
               INS_COMPARE_INCREMENT_BRANCH_EQUAL,
               INS_COMPARE_INCREMENT_BRANCH_UNEQUAL: mode_legal = 1'b1;
               default: mode_legal = 1'b0;
            endcase
         end
         default: mode_legal = 1'b0;
      endcase
   end

   // read plan: count, source and addresses
   always_comb begin
      n_reads    = READS_NONE;
      use_pm     = 1'b0;
      addr_first = {ZERO_BYTE, wr.rf_addr};
      unique case (mode_r)
         MODE_REGISTER,
         MODE_POINTER_REGISTER: begin
            n_reads = wide_r ? READS_TWO : READS_ONE;
         end
         MODE_BASE_OFFSET: begin
            n_reads = (target_r == TGT_REGISTER_FILE) ? READS_ONE : READS_TWO;
         end
         MODE_VECTOR_TABLE_CALL: begin
            n_reads    = READS_TWO;
            use_pm     = 1'b1;
            addr_first = {VECTOR_PAGE, imm_r[7:0]};
         end
         default: n_reads = READS_NONE;
      endcase
      if (!mode_legal) begin
         n_reads = READS_NONE;
      end
      addr_second = {addr_first[15:8], addr_first[7:0] + BYTE_STEP};
   end

   always_comb begin
      rd_issue = 1'b0;
      rd_addr  = addr_first;
      if (state_r == ST_READ_FIRST) begin
         rd_issue = (n_reads != READS_NONE);
      end else if (state_r == ST_READ_SECOND) begin
         rd_issue = (n_reads == READS_TWO);
         rd_addr  = addr_second;
      end
   end

   assign rf_rd_en   = rd_issue && !use_pm;
   assign rf_rd_addr = rd_addr[7:0];
   assign pm_rd_en   = rd_issue && use_pm;
   assign pm_rd_addr = rd_addr;
   assign rd_data    = use_pm ? pm_rd_data : rf_rd_data;
   assign req_ready  = (state_r == ST_IDLE);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (req_valid) begin
               state_nxt = ST_READ_FIRST;
            end
         end
         ST_READ_FIRST: begin
            state_nxt = (n_reads == READS_NONE) ? ST_CALC : ST_READ_SECOND;
         end
         ST_READ_SECOND: state_nxt = ST_CALC;
         ST_CALC:        state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // request capture
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_r      <= MODE_REGISTER;
         instr_r     <= INS_OTHER;
         target_r    <= TGT_REGISTER_FILE;
         reg_r       <= ZERO_BYTE;
         short_reg_r <= 1'b0;
         wide_r      <= 1'b0;
         short_off_r <= 1'b0;
         imm_r       <= ZERO_WORD;
         pc_r        <= ZERO_WORD;
      end else if (req_valid && req_ready) begin
         mode_r      <= req_mode;
         instr_r     <= req_instr;
         target_r    <= req_target;
         reg_r       <= req_reg;
         short_reg_r <= req_short_reg;
         wide_r      <= req_wide;
         short_off_r <= req_short_offset;
         imm_r       <= req_imm;
         pc_r        <= req_pc;
      end
   end

   // first byte read lands in read-second
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         byte_hi_r <= ZERO_BYTE;
      end else if (state_r == ST_READ_SECOND) begin
         byte_hi_r <= rd_data;
      end
   end

   // effective address and operand arithmetic
   always_comb begin
      pair_word    = {byte_hi_r, rd_data};
      sum_rf       = imm_r[7:0] + byte_hi_r;
      mem_offset   = short_off_r ? {{8{imm_r[7]}}, imm_r[7:0]} : imm_r;
      rel_disp     = {{8{imm_r[7]}}, imm_r[7:0]};
      out_of_range = 1'b0;
      kind_nxt     = KIND_VALUE;
      value_nxt    = ZERO_WORD;
      unique case (mode_r)
         MODE_REGISTER: begin
            value_nxt = wide_r ? pair_word : {ZERO_BYTE, byte_hi_r};
         end
         MODE_POINTER_REGISTER: begin
            // byte points to register, pair to memory
            if (wide_r) begin
               kind_nxt  = KIND_MEM_ADDR;
               value_nxt = pair_word;
            end else begin
               kind_nxt     = KIND_RF_ADDR;
               value_nxt    = {ZERO_BYTE, byte_hi_r};
               out_of_range = (byte_hi_r >= UPPER_SET_FIRST);
            end
         end
         MODE_BASE_OFFSET: begin
            if (target_r == TGT_REGISTER_FILE) begin
               kind_nxt     = KIND_RF_ADDR;
               value_nxt    = {ZERO_BYTE, sum_rf};
               out_of_range = (sum_rf >= UPPER_SET_FIRST);
            end else begin
               kind_nxt  = KIND_MEM_ADDR;
               value_nxt = pair_word + mem_offset;
            end
         end
         MODE_ABSOLUTE_ADDRESS: begin
            kind_nxt  = (target_r == TGT_PROGRAM_COUNTER) ? KIND_NEXT_PC : KIND_MEM_ADDR;
            value_nxt = imm_r;
         end
         MODE_VECTOR_TABLE_CALL: begin
            kind_nxt  = KIND_NEXT_PC;
            value_nxt = pair_word;
         end
         MODE_PC_OFFSET: begin
            kind_nxt  = KIND_NEXT_PC;
            value_nxt = pc_r + rel_disp;
         end
         MODE_LITERAL_OPERAND: begin
            value_nxt = wide_r ? imm_r : {ZERO_BYTE, imm_r[7:0]};
         end
         default: begin
            value_nxt = ZERO_WORD;
         end
      endcase
      illegal_nxt = !mode_legal || out_of_range;
      if (illegal_nxt) begin
         value_nxt = ZERO_WORD;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_valid_r <= 1'b0;
      end else begin
         out_valid_r <= (state_r == ST_CALC);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_illegal_r <= 1'b0;
         out_kind_r    <= KIND_VALUE;
         out_value_r   <= ZERO_WORD;
      end else if (state_r == ST_CALC) begin
         out_illegal_r <= illegal_nxt;
         out_kind_r    <= kind_nxt;
         out_value_r   <= value_nxt;
      end
   end

   assign out_valid   = out_valid_r;
   assign out_illegal = out_illegal_r;
   assign out_kind    = out_kind_r;
   assign out_value   = out_value_r;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   AST_ANSWER_BOUND: assert property (
      (req_valid && req_ready) |-> ##[3:4] out_valid)
      else $error("request not answered in three to four cycles");

   AST_PTR_NO_UPPER: assert property (
      (out_valid && !out_illegal && mode_r == MODE_POINTER_REGISTER && !wide_r)
      |-> (out_kind == KIND_RF_ADDR && out_value < {ZERO_BYTE, UPPER_SET_FIRST}))
      else $error("pointer mode produced upper control address");

   AST_BASE_NO_UPPER: assert property (
      (out_valid && mode_r == MODE_BASE_OFFSET && target_r == TGT_REGISTER_FILE
       && instr_r == INS_LOAD_REGISTER)
      |-> (out_illegal == ((imm_r[7:0] + byte_hi_r) >= UPPER_SET_FIRST)))
      else $error("base offset upper range check wrong");

   AST_BASE_WRAP: assert property (
      (out_valid && !out_illegal && mode_r == MODE_BASE_OFFSET
       && target_r == TGT_REGISTER_FILE)
      |-> (out_value == {ZERO_BYTE, 8'(imm_r[7:0] + byte_hi_r)}))
      else $error("register base offset sum wrong");

   AST_ABS_JUMP: assert property (
      (out_valid && !out_illegal && mode_r == MODE_ABSOLUTE_ADDRESS
       && target_r == TGT_PROGRAM_COUNTER)
      |-> (out_kind == KIND_NEXT_PC && out_value == imm_r))
      else $error("absolute target not passed to program counter");

   AST_VECTOR_PAGE: assert property (
      pm_rd_en |-> (pm_rd_addr[15:8] == VECTOR_PAGE
                    && pm_rd_addr[7:0] == (imm_r[7:0] + ((state_r == ST_READ_SECOND)
                                                         ? BYTE_STEP : ZERO_BYTE))))
      else $error("vector fetch outside lowest page");

   AST_VECTOR_CALL_ONLY: assert property (
      (out_valid && mode_r == MODE_VECTOR_TABLE_CALL)
      |-> (out_illegal == (instr_r != INS_CALL)))
      else $error("vector mode legality wrong");

   AST_REL_TARGET: assert property (
      (out_valid && !out_illegal && mode_r == MODE_PC_OFFSET)
      |-> (out_value == 16'(pc_r + {{8{imm_r[7]}}, imm_r[7:0]})))
      else $error("relative target wrong");

   AST_REL_USERS: assert property (
      (out_valid && mode_r == MODE_PC_OFFSET && (instr_r == INS_LOAD_REGISTER
       || instr_r == INS_CALL || instr_r == INS_JUMP_ABSOLUTE)) |-> out_illegal)
      else $error("pc offset accepted for non-branch");

   AST_LITERAL_BYTE: assert property (
      (out_valid && mode_r == MODE_LITERAL_OPERAND && !wide_r)
      |-> (out_value == {ZERO_BYTE, imm_r[7:0]}))
      else $error("byte literal not zero-extended");

endmodule : oag_operand_addr_gen

// *** hdl/oag_pkg.sv ***
package oag_pkg;

   // addressing modes, one code each
   typedef enum logic [2:0] {
      MODE_REGISTER,
      MODE_POINTER_REGISTER,
      MODE_BASE_OFFSET,
      MODE_ABSOLUTE_ADDRESS,
      MODE_VECTOR_TABLE_CALL,
      MODE_PC_OFFSET,
      MODE_LITERAL_OPERAND
   } oag_mode_type;

   typedef enum logic [3:0] {
      INS_LOAD_REGISTER,
      INS_LOAD_PROGRAM_MEMORY,
      INS_LOAD_EXTERNAL_DATA,
      INS_JUMP_ABSOLUTE,
      INS_CALL,
      INS_JUMP_RELATIVE,
      INS_DECREMENT_BRANCH_NONZERO,
      INS_BIT_TEST_BRANCH_FALSE,
      INS_BIT_TEST_BRANCH_TRUE,
      INS_COMPARE_INCREMENT_BRANCH_EQUAL,
      INS_COMPARE_INCREMENT_BRANCH_UNEQUAL,
      INS_OTHER
   } oag_instr_type;

   typedef enum logic [1:0] {
      TGT_REGISTER_FILE,
      TGT_PROGRAM_MEMORY,
      TGT_EXTERNAL_DATA,
      TGT_PROGRAM_COUNTER
   } oag_target_type;

   typedef enum logic [1:0] {
      KIND_VALUE,
      KIND_RF_ADDR,
      KIND_MEM_ADDR,
      KIND_NEXT_PC
   } oag_kind_type;

   localparam int unsigned MODE_COUNT         = 7;
   localparam logic [7:0]  UPPER_SET_FIRST    = 8'hC0;
   localparam logic [3:0]  WREG_SELECT_NIBBLE = 4'hC;
   localparam int unsigned WREG_POINTER_BIT   = 3;
   localparam logic [7:0]  VECTOR_PAGE        = 8'h00;
   localparam logic [7:0]  BYTE_STEP          = 8'h01;
   localparam logic [7:0]  ZERO_BYTE          = 8'h00;
   localparam logic [15:0] ZERO_WORD          = 16'h0000;
   localparam logic [1:0]  READS_NONE         = 2'h0;
   localparam logic [1:0]  READS_ONE          = 2'h1;
   localparam logic [1:0]  READS_TWO          = 2'h2;

endpackage : oag_pkg

// *** hdl/oag_wreg_if.sv ***
`timescale 1ns/1ps
interface oag_wreg_if;
   logic [7:0] reg_field;
   logic       short_form;
   logic [7:0] rp0;
   logic [7:0] rp1;
   logic [7:0] rf_addr;
   logic       working;

   modport resolver (
      input  reg_field,
      input  short_form,
      input  rp0,
      input  rp1,
      output rf_addr,
      output working
   );

   modport requester (
      output reg_field,
      output short_form,
      output rp0,
      output rp1,
      input  rf_addr,
      input  working
   );
endinterface : oag_wreg_if

// *** hdl/oag_wreg_resolve.sv ***
`timescale 1ns/1ps
module oag_wreg_resolve
   import oag_pkg::*;
(
   input wire logic         core_clk,
   input wire logic         rst_b,
   oag_wreg_if.resolver     wr
);

   logic [7:0] ptr;

   always_comb begin
      wr.working = wr.short_form || (wr.reg_field[7:4] == WREG_SELECT_NIBBLE);
      ptr = wr.reg_field[WREG_POINTER_BIT] ? wr.rp1 : wr.rp0;
      wr.rf_addr = wr.working ? {ptr[7:3], wr.reg_field[2:0]} : wr.reg_field;
   end

   AST_WREG_CONCAT: assert property (@(posedge core_clk) disable iff (!rst_b)
      wr.working |-> (wr.rf_addr == {(wr.reg_field[3] ? wr.rp1[7:3] : wr.rp0[7:3]),
                                     wr.reg_field[2:0]}))
      else $error("working address not built from pointer and field");

   AST_WREG_NIBBLE: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!wr.short_form && wr.reg_field[7:4] != WREG_SELECT_NIBBLE)
      |-> (!wr.working && wr.rf_addr == wr.reg_field))
      else $error("plain register address was altered");

endmodule : oag_wreg_resolve

// *** verif/oag_mem_model.sv ***
`timescale 1ns/1ps
module oag_mem_model (
   input  wire logic        core_clk,
   input  wire logic        rf_rd_en,
   input  wire logic [7:0]  rf_rd_addr,
   output logic [7:0]       rf_rd_data,
   input  wire logic        pm_rd_en,
   input  wire logic [15:0] pm_rd_addr,
   output logic [7:0]       pm_rd_data
);
   logic [7:0] rf_mem [256];
   logic [7:0] pm_mem [256];

   initial begin
      for (int i = 0; i < 256; i++) begin
         rf_mem[i] = 8'(i * 59 + 17);
         pm_mem[i] = 8'(i * 113) ^ 8'h96;
      end
      rf_rd_data = 8'h00;
      pm_rd_data = 8'h00;
   end

   // one-cycle register read
   // idle cycles flip the bus so stale data is never mistaken for fresh
   always @(posedge core_clk) begin
      rf_rd_data <= rf_rd_en ? rf_mem[rf_rd_addr] : ~rf_rd_data;
   end

   always @(posedge core_clk) begin
      if (pm_rd_en && pm_rd_addr[15:8] == 8'h00) begin
         pm_rd_data <= pm_mem[pm_rd_addr[7:0]];
      end else begin
         pm_rd_data <= ~pm_rd_data;
      end
   end
endmodule : oag_mem_model

// *** verif/operand_address_generator_test.sv ***
`timescale 1ns/1ps
module operand_address_generator_test
   import oag_pkg::*;
   ;
   logic           core_clk, rst_b, req_valid, req_ready, req_short_reg, req_wide;
   logic           req_short_offset, rf_rd_en, pm_rd_en, out_valid, out_illegal;
   oag_mode_type   req_mode;
   oag_instr_type  req_instr;
   oag_target_type req_target;
   oag_kind_type   out_kind, e_kind;
   logic [7:0]     req_reg, rp0, rp1, rf_rd_addr, rf_rd_data, pm_rd_data;
   logic [15:0]    req_imm, req_pc, pm_rd_addr, out_value, e_val;
   logic           e_ill;
   logic [15:0]    e_rf [$];
   logic [15:0]    e_pm [$];
   logic [31:0]    seed = 32'h0001_0865;
   int             err_count, checks_done;

   oag_operand_addr_gen u_oag_operand_addr_gen (
      .core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
      .req_mode(req_mode), .req_instr(req_instr), .req_target(req_target),
      .req_reg(req_reg), .req_short_reg(req_short_reg), .req_wide(req_wide),
      .req_short_offset(req_short_offset), .req_imm(req_imm), .req_pc(req_pc),
      .rp0(rp0), .rp1(rp1), .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr),
      .rf_rd_data(rf_rd_data), .pm_rd_en(pm_rd_en), .pm_rd_addr(pm_rd_addr),
      .pm_rd_data(pm_rd_data), .out_valid(out_valid), .out_illegal(out_illegal),
      .out_kind(out_kind), .out_value(out_value));

   oag_mem_model u_oag_mem_model (
      .core_clk(core_clk), .rf_rd_en(rf_rd_en), .rf_rd_addr(rf_rd_addr),
      .rf_rd_data(rf_rd_data), .pm_rd_en(pm_rd_en), .pm_rd_addr(pm_rd_addr),
      .pm_rd_data(pm_rd_data));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask : check

   function automatic logic [7:0] rf(input logic [7:0] a);
      return u_oag_mem_model.rf_mem[a];
   endfunction : rf

   function automatic logic [7:0] pm(input logic [7:0] a);
      return u_oag_mem_model.pm_mem[a];
   endfunction : pm

   function automatic logic mem_ok();
      return (req_target == TGT_PROGRAM_MEMORY && req_instr == INS_LOAD_PROGRAM_MEMORY) ||
             (req_target == TGT_EXTERNAL_DATA && req_instr == INS_LOAD_EXTERNAL_DATA);
   endfunction : mem_ok

   task automatic ref_model();
      logic [7:0]  a, b, p, v;
      logic [15:0] pr, sx;
      logic        ok;
      int          nr;
      p = req_reg[3] ? rp1 : rp0;
      a = (req_short_reg || req_reg[7:4] == 4'hC) ? {p[7:3], req_reg[2:0]} : req_reg;
      b = a + 8'h01;
      pr = {rf(a), rf(b)};
      sx = {{8{req_imm[7]}}, req_imm[7:0]};
      v = req_imm[7:0] + rf(a);
      ok = 1'b1;
      e_ill = 1'b0;
      e_kind = KIND_VALUE;
      e_pm = {};
      nr = req_wide ? 2 : 1;
      e_val = req_wide ? pr : {8'h00, rf(a)};
      case (req_mode)
         MODE_REGISTER: ;
         MODE_POINTER_REGISTER: begin
            e_kind = req_wide ? KIND_MEM_ADDR : KIND_RF_ADDR;
            e_ill = !req_wide && rf(a) >= UPPER_SET_FIRST;
         end
         MODE_BASE_OFFSET: begin
            if (req_target == TGT_REGISTER_FILE) begin
               ok = req_instr == INS_LOAD_REGISTER;
               nr = 1;
               e_kind = KIND_RF_ADDR;
               e_val = {8'h00, v};
               e_ill = v >= UPPER_SET_FIRST;
            end else begin
               ok = mem_ok();
               nr = 2;
               e_kind = KIND_MEM_ADDR;
               e_val = pr + (req_short_offset ? sx : req_imm);
            end
         end
         MODE_ABSOLUTE_ADDRESS: begin
            nr = 0;
            e_val = req_imm;
            e_kind = req_target == TGT_PROGRAM_COUNTER ? KIND_NEXT_PC : KIND_MEM_ADDR;
            ok = req_target == TGT_PROGRAM_COUNTER ?
                 (req_instr == INS_JUMP_ABSOLUTE || req_instr == INS_CALL) : mem_ok();
         end
         MODE_VECTOR_TABLE_CALL: begin
            nr = 0;
            e_pm.push_back({8'h00, req_imm[7:0]});
            e_pm.push_back({8'h00, req_imm[7:0] + 8'h01});
            e_val = {pm(req_imm[7:0]), pm(req_imm[7:0] + 8'h01)};
            e_kind = KIND_NEXT_PC;
            ok = req_instr == INS_CALL;
         end
         MODE_PC_OFFSET: begin
            nr = 0;
            e_val = req_pc + sx;
            e_kind = KIND_NEXT_PC;
            ok = req_instr inside {INS_JUMP_RELATIVE, INS_DECREMENT_BRANCH_NONZERO,
                 INS_BIT_TEST_BRANCH_FALSE, INS_BIT_TEST_BRANCH_TRUE,
                 INS_COMPARE_INCREMENT_BRANCH_EQUAL, INS_COMPARE_INCREMENT_BRANCH_UNEQUAL};
         end
         default: begin
            nr = 0;
            e_val = req_wide ? req_imm : {8'h00, req_imm[7:0]};
         end
      endcase
      if (!ok) begin
         e_ill = 1'b1;
         nr = 0;
         e_pm = {};
      end
      e_rf = {};
      if (nr > 0) e_rf.push_back({8'h00, a});
      if (nr > 1) e_rf.push_back({8'h00, b});
      if (e_ill) begin
         e_val = 16'h0000;
      end
   endtask : ref_model

   task automatic run_req(input int m, input int i, input int t);
      logic [31:0] r, s;
      logic [15:0] q_rf [$];
      logic [15:0] q_pm [$];
      int          n;
      r = rnd();
      s = rnd();
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_mode <= oag_mode_type'(3'(m));
      req_instr <= oag_instr_type'(4'(i));
      req_target <= oag_target_type'(2'(t));
      req_reg <= r[0] ? {4'hC, r[11:8]} : r[15:8];
      req_short_reg <= r[1];
      req_wide <= r[2];
      req_short_offset <= r[3];
      req_imm <= r[31:16];
      req_pc <= s[15:0];
      rp0 <= s[23:16];
      rp1 <= s[31:24];
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         complete_run();
      end
      ref_model();
      @(posedge core_clk);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
         if (rf_rd_en === 1'b1) q_rf.push_back({8'h00, rf_rd_addr});
         if (pm_rd_en === 1'b1) q_pm.push_back(pm_rd_addr);
         if (out_valid !== 1'b1) check({15'h0000, req_ready}, 16'h0000);
      end while (out_valid !== 1'b1 && n < 10);
      if (n >= 10) begin
         err_count++;
         complete_run();
      end
      check(16'(n), (e_rf.size() + e_pm.size() > 0) ? 16'h0004 : 16'h0003);
      check(16'(q_rf.size()), 16'(e_rf.size()));
      foreach (q_rf[j]) if (j < e_rf.size()) check(q_rf[j], e_rf[j]);
      check(16'(q_pm.size()), 16'(e_pm.size()));
      foreach (q_pm[j]) if (j < e_pm.size()) check(q_pm[j], e_pm[j]);
      check({15'h0000, out_illegal}, {15'h0000, e_ill});
      check(out_value, e_val);
      if (!e_ill) check({14'h0000, out_kind}, {14'h0000, e_kind});
   endtask : run_req

   task automatic do_reset();
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check({15'h0000, out_valid}, 16'h0000);
      check({15'h0000, req_ready}, 16'h0001);
      check({15'h0000, out_illegal}, 16'h0000);
      check(out_value, 16'h0000);
      @(posedge core_clk);
      rst_b <= 1'b1;
   endtask : do_reset

   initial begin
      logic [31:0] r;
      rst_b = 1'b0;
      req_valid = 1'b0;
      req_mode = MODE_REGISTER;
      req_instr = INS_OTHER;
      req_target = TGT_REGISTER_FILE;
      req_reg = 8'h00;
      req_short_reg = 1'b0;
      req_wide = 1'b0;
      req_short_offset = 1'b0;
      req_imm = 16'h0000;
      req_pc = 16'h0000;
      rp0 = 8'h00;
      rp1 = 8'h00;
      do_reset();
      // every mode, instruction and target code in turn
      for (int m = 0; m < 7; m++)
         for (int i = 0; i < 12; i++)
            for (int t = 0; t < 4; t++)
               run_req(m, i, t);
      $display("test sweep done");
      do_reset();
      $display("test reset done");
      repeat (200) begin
         r = rnd();
         run_req(int'(r[7:0]) % 7, int'(r[15:8]) % 12, int'(r[17:16]));
      end
      $display("test random done");
      complete_run();
   end
endmodule : operand_address_generator_test
